// file: logic/srw_core.sv
// spi register read/write frame interpreter
//
// Overview of operation
// - read response opens 0110, status, two zeros
// - high byte (odd address) in bits 23:16
// - low byte in bits 15:8, crc last
// - accepted write stores data at byte address
// - write only without spi or verify error
// - lock bit blocks writes except restart bits
// - invalid register request refuses the write
// - failed write: nothing changes, error response
// - write applied only after select rises
// - read-only target unchanged, normal response
// - write response code 0100, read layout
// - read bytes sampled at select rise
module srw_core
  import srw_pkg::*;
#(
  parameter int N_REGS = NUM_REGS
) (
  // clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // spi pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_sel_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  // error inputs from checkers and crc
  input  wire logic       spi_err,
  input  wire logic       verify_err,
  input  wire logic       req_invalid,
  input  wire logic [1:0] basic_status_field,
  input  wire logic [7:0] rsp_crc,
  // status
  output logic            init_complete_lock,
  output logic            wr_done,
  output logic            wr_refused
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_s_q;
  logic [1:0] sel_s_q;
  logic [1:0] mosi_s_q;

  // serial clock idles low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s_q <= SYNC_LOW;
    end else if (clk_en) begin
      sclk_s_q <= {sclk_s_q[0], spi_sclk};
    end
  end

  // select idles high, so reset shows no frame start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s_q <= SYNC_HIGH;
    end else if (clk_en) begin
      sel_s_q <= {sel_s_q[0], spi_sel_n};
    end
  end

  // command data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mosi_s_q <= SYNC_LOW;
    end else if (clk_en) begin
      mosi_s_q <= {mosi_s_q[0], spi_mosi};
    end
  end

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic sclk_d1_q;
  logic sel_d1_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d1_q <= PIN_LOW;
    end else if (clk_en) begin
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_d1_q <= PIN_HIGH;
    end else if (clk_en) begin
      sel_d1_q <= sel_s_q[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic active;

  assign sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  assign sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
  assign sel_fall  = ~sel_s_q[1] & sel_d1_q;
  assign sel_rise  = sel_s_q[1] & ~sel_d1_q;
  assign active    = ~sel_s_q[1];

  // ----------------------------------------
  // command shift in
  // ----------------------------------------
  logic [FRAME_BITS-1:0] rx_q;
  logic [5:0]            cnt_q;

  // command bits enter msb first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= '0;
    end else if (clk_en) begin
      if (active && sclk_rise && !sel_fall) begin
        rx_q <= {rx_q[FRAME_BITS-2:0], mosi_s_q[1]};
      end
    end
  end

  // counter saturates, long frames keep their last bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= BIT_CNT_ZERO;
    end else if (clk_en) begin
      if (sel_fall) begin
        cnt_q <= BIT_CNT_ZERO;
      end else if (active && sclk_rise && cnt_q != BIT_CNT_FULL) begin
        cnt_q <= cnt_q + BIT_CNT_STEP;
      end
    end
  end

  // ----------------------------------------
  // frame decode
  // ----------------------------------------
  logic [3:0] cmd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] lo_addr;
  logic [7:0] hi_addr;
  logic       full;
  logic       is_rd;
  logic       is_wr;
  logic       frame_ok;

  assign cmd      = rx_q[CMD_MSB:CMD_LSB];
  assign addr     = rx_q[ADDR_MSB:ADDR_LSB];
  assign wdata    = rx_q[DATA_MSB:DATA_LSB];
  // word address picks the byte pair
  assign lo_addr  = addr & ~WORD_SEL_BIT;
  assign hi_addr  = addr | WORD_SEL_BIT;
  assign full     = (cnt_q == BIT_CNT_FULL);
  assign is_rd    = full && (cmd == CMD_RD_REQ);
  assign is_wr    = full && (cmd == CMD_WR_REQ);
  // error inputs are levels, read at select rise
  assign frame_ok = full && !spi_err && !verify_err;

  // ----------------------------------------
  // write acceptance
  // ----------------------------------------
  logic [7:0] regs_q [N_REGS];
  logic       locked;
  logic       restart_only;
  logic       ro_target;
  logic       rd_ok;
  logic       wr_ok;
  logic       wr_apply;

  assign locked       = regs_q[LOCK_WR_ADDR][LOCK_BIT];
  // under lock only the restart bits may differ
  assign restart_only = (addr == LOCK_WR_ADDR)
                     && ((wdata & ~RESTART_MASK) ==
                         (regs_q[LOCK_WR_ADDR] & ~RESTART_MASK));
  assign ro_target    = (addr >= RO_BASE);
  assign rd_ok        = is_rd && frame_ok && !req_invalid;
  assign wr_ok        = is_wr && frame_ok && !req_invalid
                     && (!locked || restart_only);
  assign wr_apply     = sel_rise && wr_ok && !ro_target;

  // ----------------------------------------
  // register array
  // ----------------------------------------
  // bytes land only after the carrying frame has ended
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (clk_en) begin
      if (wr_apply) begin
        regs_q[addr] <= wdata;
      end
    end
  end

  // ----------------------------------------
  // response frame build
  // ----------------------------------------
  logic [FRAME_BITS-1:0] rd_frame;
  logic [FRAME_BITS-1:0] wr_frame;
  logic [FRAME_BITS-1:0] err_frame;
  logic [FRAME_BITS-1:0] next_frame;

  // bytes are read out before a write of the same frame lands
  assign rd_frame  = {CODE_RD_RSP, basic_status_field, PAD_ZERO,
                      regs_q[hi_addr], regs_q[lo_addr], rsp_crc};
  assign wr_frame  = {CODE_WR_RSP, basic_status_field, PAD_ZERO,
                      regs_q[hi_addr], regs_q[lo_addr], rsp_crc};
  assign err_frame = {CODE_ERR_RSP, ERR_STATUS, PAD_ZERO,
                      BYTE_ZERO, BYTE_ZERO, rsp_crc};

  // refused writes and unknown frames answer with an error
  always_comb begin
    if (rd_ok) begin
      next_frame = rd_frame;
    end else if (wr_ok) begin
      next_frame = wr_frame;
    end else begin
      next_frame = err_frame;
    end
  end

  // ----------------------------------------
  // response shift out
  // ----------------------------------------
  logic [FRAME_BITS-1:0] tx_q;

  // loaded at select rise, sent during the next frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= '0;
    end else if (clk_en) begin
      if (sel_rise) begin
        tx_q <= next_frame;
      end else if (active && sclk_fall && !sel_fall) begin
        tx_q <= {tx_q[FRAME_BITS-2:0], PIN_LOW};
      end
    end
  end

  // ----------------------------------------
  // write status pulses
  // ----------------------------------------
  logic wr_done_q;
  logic wr_refused_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_done_q <= PIN_LOW;
    end else if (clk_en) begin
      wr_done_q <= wr_apply;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_refused_q <= PIN_LOW;
    end else if (clk_en) begin
      wr_refused_q <= sel_rise && is_wr && !wr_ok;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic miso_q;
  logic miso_oe_q;
  logic lock_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_q <= PIN_LOW;
    end else if (clk_en) begin
      miso_q <= tx_q[FRAME_BITS-1];
    end
  end

  // miso driven only while select is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_oe_q <= PIN_LOW;
    end else if (clk_en) begin
      miso_oe_q <= active;
    end
  end

  // lock copy lets the host see when writes close
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= PIN_LOW;
    end else if (clk_en) begin
      lock_q <= locked;
    end
  end

  assign spi_miso           = miso_q;
  assign spi_miso_oe        = miso_oe_q;
  assign init_complete_lock = lock_q;
  assign wr_done            = wr_done_q;
  assign wr_refused         = wr_refused_q;
endmodule

// file: logic/srw_pkg.sv
// constants for the spi register read/write frame block
package srw_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int          FRAME_BITS   = 32;
  localparam int          CMD_MSB      = 31;
  localparam int          CMD_LSB      = 28;
  localparam int          ADDR_MSB     = 23;
  localparam int          ADDR_LSB     = 16;
  localparam int          DATA_MSB     = 15;
  localparam int          DATA_LSB     = 8;
  localparam int          CRC_MSB      = 7;
  localparam int          CRC_LSB      = 0;
  localparam logic [3:0]  CMD_RD_REQ   = 4'hC;
  localparam logic [3:0]  CMD_WR_REQ   = 4'h8;
  localparam logic [3:0]  CODE_RD_RSP  = 4'h6;
  localparam logic [3:0]  CODE_WR_RSP  = 4'h4;
  localparam logic [3:0]  CODE_ERR_RSP = 4'h0;
  localparam logic [1:0]  ERR_STATUS   = 2'h3;
  localparam logic [1:0]  PAD_ZERO     = 2'h0;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [5:0]  BIT_CNT_ZERO = 6'h00;
  localparam logic [5:0]  BIT_CNT_FULL = 6'h20;
  localparam logic [5:0]  BIT_CNT_STEP = 6'h01;
  localparam logic [1:0]  SYNC_LOW     = 2'h0;
  localparam logic [1:0]  SYNC_HIGH    = 2'h3;
  localparam logic        PIN_LOW      = 1'h0;
  localparam logic        PIN_HIGH     = 1'h1;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int          NUM_REGS     = 256;
  localparam logic [7:0]  LOCK_WR_ADDR = 8'h10;
  localparam int          LOCK_BIT     = 7;
  localparam logic [7:0]  RESTART_MASK = 8'h03;
  localparam logic [7:0]  RO_BASE      = 8'h80;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  WORD_SEL_BIT = 8'h01;
endpackage

// file: test/srw_core_bench.sv
// self-checking bench for the spi frame block
module srw_core_bench import srw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0, rst_n = 1'h0;
  logic spi_sclk, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe;
  logic spi_err, verify_err, req_invalid, init_complete_lock;
  logic [1:0] basic_status_field;
  logic [7:0] rsp_crc;
  logic [7:0] m [256];
  int mismatches, n_checks, cyc, seed = 11942;
  logic wr_done, wr_refused;
  int n_done, n_refused, e_done, e_refused;
  srw_core dut (.core_clk, .rst_n, .clk_en(1'h1), .spi_sclk, .spi_sel_n,
    .spi_mosi, .spi_miso, .spi_miso_oe, .spi_err, .verify_err,
    .req_invalid, .basic_status_field, .rsp_crc, .init_complete_lock,
    .wr_done, .wr_refused);
  srw_host host (.spi_sclk, .spi_sel_n, .spi_mosi, .spi_miso);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 50000) begin
    mismatches++;
    complete_run();
  end
  always @(posedge core_clk) begin
    if (wr_done === 1'h1) n_done++;
    if (wr_refused === 1'h1) n_refused++;
  end
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] predict(logic [31:0] f);
    logic [7:0] a, d, hi, lo;
    logic ok;
    a = f[23:16];
    d = f[15:8];
    hi = m[a | 8'h01];
    lo = m[a & 8'hFE];
    ok = !spi_err && !verify_err;
    if (f[31:28] == CMD_RD_REQ && ok)
      return {CODE_RD_RSP, basic_status_field, 2'h0, hi, lo, rsp_crc};
    ok = ok && !req_invalid && (!m[LOCK_WR_ADDR][LOCK_BIT]
      || (a == LOCK_WR_ADDR && ((d ^ m[a]) & ~RESTART_MASK) == 8'h00));
    if (f[31:28] == CMD_WR_REQ && !ok)
      e_refused++;
    if (f[31:28] != CMD_WR_REQ || !ok)
      return {CODE_ERR_RSP, ERR_STATUS, 18'h0, rsp_crc};
    if (a < RO_BASE) begin
      m[a] = d;
      e_done++;
    end
    return {CODE_WR_RSP, basic_status_field, 2'h0, hi, lo, rsp_crc};
  endfunction
  initial begin
    logic [31:0] f, e, rx, expn;
    {spi_err, verify_err, req_invalid, basic_status_field} = 5'h00;
    rsp_crc = 8'h00;
    for (int p = 0; p < 2; p++) begin
      foreach (m[k]) m[k] = REG_RESET;
      rst_n = 1'h0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'h1;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 60; i++) begin
        f = $random(seed);
        e = $random(seed);
        f[31:28] = f[1] ? CMD_WR_REQ : (f[0] ? CMD_RD_REQ : f[31:28]);
        f[27:24] = 4'h0;
        if (f[3:2] == 2'h0) f[23:16] = 8'h10;
        if (i % 10 == 9) f[31:8] = {CMD_WR_REQ, 12'h010, m[8'h10] ^ 8'h03};
        spi_err = e[2:0] == 3'h0;
        verify_err = e[5:3] == 3'h0;
        req_invalid = e[8:6] == 3'h0 && f[31:28] == CMD_WR_REQ;
        basic_status_field = e[10:9];
        rsp_crc = e[18:11];
        host.xfer(f, rx);
        if (i > 0) chk(rx, expn);
        expn = predict(f);
        chk({31'h0, init_complete_lock}, {31'h0, m[8'h10][7]});
        chk(n_done, e_done);
        chk(n_refused, e_refused);
      end
      $display("phase %0d done", p);
    end
    complete_run();
  end
endmodule

// file: test/srw_core_props.sv
// checker for the spi frame block
module srw_core_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_sel_n,
  input wire logic spi_err,
  input wire logic verify_err,
  input wire logic req_invalid,
  input wire logic spi_miso_oe,
  input wire logic init_complete_lock,
  input wire logic wr_done,
  input wire logic wr_refused
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_done_pulse: assert property (wr_done |=> !wr_done)
    else $error("long done");
  a_refuse_pulse: assert property (wr_refused |=> !wr_refused)
    else $error("long refuse");
  a_done_or_refuse: assert property (!(wr_done && wr_refused))
    else $error("done and refuse");
  a_err_blocks: assert property
    ((spi_err || verify_err || req_invalid) |-> !wr_done)
    else $error("write despite error");
  a_write_late: assert property (wr_done |-> $past(spi_sel_n, 2))
    else $error("write inside frame");
  a_lock_late: assert property
    ($changed(init_complete_lock) |-> $past(spi_sel_n, 2))
    else $error("lock moved in frame");
  a_oe_idle: assert property (spi_sel_n [*5] |-> !spi_miso_oe)
    else $error("miso driven idle");
  a_oe_frame: assert property
    ($fell(spi_sel_n) |-> ##[1:5] spi_miso_oe)
    else $error("miso not driven");
endmodule
bind srw_core srw_core_props u_props (.core_clk, .rst_n, .spi_sel_n,
  .spi_err, .verify_err, .req_invalid, .spi_miso_oe, .init_complete_lock,
  .wr_done, .wr_refused);

// file: test/srw_host.sv
// spi host model, 32-bit frames, 200 ns serial clock
module srw_host (
  output logic      spi_sclk,
  output logic      spi_sel_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {spi_sclk, spi_sel_n, spi_mosi} = 3'h2;
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    spi_sel_n = 1'h0;
    #100;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      #100 spi_sclk = 1'h1;
      #100 rx[i] = spi_miso;
      spi_sclk = 1'h0;
    end
    #100 spi_sel_n = 1'h1;
    spi_mosi = ~spi_mosi;
    #400;
  endtask
endmodule
